// ==== ssts_crc16.sv ====
// Purpose: Bit-serial transmit CRC generator.
// Assumes: Bits arrive in line order, one per bit_v pulse.
// Notes:   Clear has priority over an accumulated bit.
`timescale 1ns/1ps

module ssts_crc16 (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Bit stream
  input  wire logic        clr,
  input  wire logic        bit_v,
  input  wire logic        bit_in,
  input  wire logic        poly_sel,
  // Result
  output logic      [15:0] crc_ff
);

  logic [15:0] nxt_crc;
  logic [15:0] poly;

  always_comb begin
    poly    = poly_sel ? ssts_pkg::POLY_CRC16 : ssts_pkg::POLY_ALT;
    nxt_crc = crc_ff;
    if (clr) begin
      nxt_crc = ssts_pkg::CRC_INIT;
    end else if (bit_v) begin
      nxt_crc = {crc_ff[14:0], 1'b0} ^
                ((bit_in ^ crc_ff[15]) ? poly : 16'h0000);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_ff <= 16'h0000;
    end else if (ce) begin
      crc_ff <= nxt_crc;
    end
  end

endmodule // ssts_crc16

// ==== ssts_peer.sv ====
// Purpose: Remote sync station that clocks and captures the line.
// Assumes: The transmit clock runs only while run is high.
// Notes:   Receive data idles at mark, so no break is ever seen.
`timescale 1ns/1ps

module ssts_peer #(
  parameter logic [7:0] PAT = 8'h96
) (
  // Control
  input  wire logic run,
  input  wire logic txd,
  // Link
  output logic      tclk,
  output logic      rxd,
  output logic      hit
);
  logic [7:0] sh = 8'h00;
  logic       seen = 1'b0;
  assign rxd = 1'b1;
  assign hit = seen;
  initial begin
    tclk = 1'b1;
    forever begin
      #32;
      tclk = run ? ~tclk : 1'b1;
    end
  end
  // Bits are taken mid-cell, half a period after the shift edge.
  always @(posedge tclk) begin
    sh <= {txd, sh[7:1]};
    if ({txd, sh[7:1]} == PAT) seen <= 1'b1;
  end
endmodule // ssts_peer

// ==== ssts_pkg.sv ====
// Purpose: Shared constants of the serial transmit and status channel.
// Assumes: One channel; registers reached through a pointer.
// Notes:   Bit positions are within the 8-bit register bytes.

package ssts_pkg;

  // ---------------------------------------------------------------
  // Register pointers and commands
  // ---------------------------------------------------------------
  localparam logic [2:0] PTR_CMD    = 3'h0;
  localparam logic [2:0] PTR_INTCTL = 3'h1;
  localparam logic [2:0] PTR_RXCTL  = 3'h3;
  localparam logic [2:0] PTR_MODE   = 3'h4;
  localparam logic [2:0] PTR_TXCTL  = 3'h5;
  localparam logic [2:0] PTR_SYNC1  = 3'h6;
  localparam logic [2:0] PTR_SYNC2  = 3'h7;
  localparam logic [2:0] CMD_RST_EXT  = 3'h2;
  localparam logic [2:0] CMD_CHAN_RST = 3'h3;
  localparam logic [2:0] CMD_RST_TXIP = 3'h5;
  localparam logic [1:0] CRC_CMD_RST   = 2'h2;
  localparam logic [1:0] CRC_CMD_UNDER = 2'h3;
  localparam logic [7:0] REG_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int INT_EXT_IE = 0;
  localparam int INT_TX_IE  = 1;
  localparam int RX_EN      = 0;
  localparam int RX_AUTO    = 5;
  localparam int TX_CRCEN   = 0;
  localparam int TX_RTS     = 1;
  localparam int TX_POLY    = 2;
  localparam int TX_EN      = 3;
  localparam int TX_BRK     = 4;
  localparam int TX_LEN     = 5;
  localparam int TX_DTR     = 7;
  localparam int MD_PAR_EN  = 0;
  localparam int MD_EVEN    = 1;
  localparam int MD_STOP    = 2;
  localparam int MD_SYNC    = 4;
  localparam int MD_MULT    = 6;
  localparam int ST_IP      = 1;
  localparam int ST_TXBE    = 2;
  localparam int ST_CD      = 3;
  localparam int ST_SYNC    = 4;
  localparam int ST_CTS     = 5;
  localparam int ST_UNDER   = 6;
  localparam int ST_BRK     = 7;
  localparam logic [1:0] SYNC_16 = 2'h1;
  localparam logic [15:0] POLY_CRC16 = 16'h8005;
  localparam logic [15:0] POLY_ALT   = 16'h1021;
  localparam logic [15:0] CRC_INIT   = 16'h0000;

  // ---------------------------------------------------------------
  // Types and decoders
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    S_OFF   = 2'b00,
    S_SHIFT = 2'b01,
    S_STOP  = 2'b10
  } ssts_state_t;

  typedef enum logic [1:0] {
    K_SYNC = 2'b00,
    K_DATA = 2'b01,
    K_CRC  = 2'b10
  } ssts_kind_t;

  function automatic logic [3:0] len_of(input logic [1:0] code);
    case (code)
      2'b00:   len_of = 4'd5;
      2'b01:   len_of = 4'd7;
      2'b10:   len_of = 4'd6;
      default: len_of = 4'd8;
    endcase
  endfunction

  function automatic logic [6:0] mult_of(input logic [1:0] code);
    case (code)
      2'b00:   mult_of = 7'd1;
      2'b01:   mult_of = 7'd16;
      2'b10:   mult_of = 7'd32;
      default: mult_of = 7'd64;
    endcase
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] x);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = x[15 - i];
    end
  endfunction

endpackage

// ==== ssts_top.sv ====
// Purpose: One serial channel: status latches and transmitter.
// Assumes: Host strobes are synchronous to clk; link pins are not.
// Notes:   Receiver data path is absent; only break is watched.
`timescale 1ns/1ps

module ssts_top #(
  parameter int unsigned BRK_BITS = 16
) (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Host port
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic       sel_ctrl,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_ff,
  output logic            host_wait_ff,
  output logic            irq_ff,
  output logic            tx_dma_req_ff,
  // Link pins
  input  wire logic       transmit_clock,
  input  wire logic       receive_clock,
  input  wire logic       rxd,
  input  wire logic       cts_n,
  input  wire logic       cd_n,
  input  wire logic       sync_detect_pin,
  output logic            txd_ff,
  output logic            rts_n_ff,
  output logic            dtr_n_ff
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [1:0] s3_ff;
  logic       tx_fall;
  logic       rx_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Reset to the pins' idle levels so no false change is latched.
      s1_ff <= 6'h1f;
      s2_ff <= 6'h1f;
      s3_ff <= 2'h3;
    end else if (ce) begin
      s1_ff <= {sync_detect_pin, cd_n, cts_n, rxd,
                receive_clock, transmit_clock};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[1:0];
    end
  end

  assign tx_fall = !s2_ff[0] && s3_ff[0];
  assign rx_rise = s2_ff[1] && !s3_ff[1];

  // ---------------------------------------------------------------
  // State declarations
  // ---------------------------------------------------------------
  logic [2:0]  ptr_ff, nxt_ptr;
  logic [7:0]  intctl_ff, nxt_intctl;
  logic [7:0]  rxctl_ff, nxt_rxctl;
  logic [7:0]  mode_ff, nxt_mode;
  logic [7:0]  txctl_ff, nxt_txctl;
  logic [7:0]  sync1_ff, nxt_sync1;
  logic [7:0]  sync2_ff, nxt_sync2;
  logic [7:0]  buf_ff, nxt_buf;
  logic [7:0]  pdata_ff, nxt_pdata;
  logic        full_ff, nxt_full;
  logic        pend_ff, nxt_pend;
  logic        txip_ff, nxt_txip;
  logic        extip_ff, nxt_extip;
  logic        latch_ff, nxt_latch;
  logic [3:0]  snap_ff, nxt_snap;
  logic        under_ff, nxt_under;
  logic [7:0]  brk_ff, nxt_brk;
  logic [7:0]  nxt_rdata;
  logic        nxt_irq, nxt_dma;
  logic [15:0] crc_q;
  ssts_pkg::ssts_state_t state_ff, nxt_state;
  ssts_pkg::ssts_kind_t  kind_ff, nxt_kind;
  logic [15:0] sh_ff, nxt_sh;
  logic [4:0]  nbits_ff, nxt_nbits;
  logic [7:0]  div_ff, nxt_div;
  logic        crcinc_ff, nxt_crcinc;
  logic        nxt_txd;
  logic        ld_data, ev_under, ev_fill, ev_txip, bit_v, do_load;
  logic        cmd_wr, chan_rst, crc_clr, cts_act, txen, is_async;
  logic        crc_busy, brk_live;
  logic [3:0]  live, clen;
  logic [6:0]  mult;
  logic [7:0]  stop_edges, st, dmask;

  assign cmd_wr   = wr_stb && sel_ctrl && ptr_ff == ssts_pkg::PTR_CMD;
  assign chan_rst = cmd_wr && wdata[5:3] == ssts_pkg::CMD_CHAN_RST;
  assign crc_clr  = chan_rst ||
                    (cmd_wr && wdata[7:6] == ssts_pkg::CRC_CMD_RST);
  assign cts_act  = !s2_ff[3];
  assign brk_live = brk_ff == 8'(BRK_BITS);
  assign live     = {brk_live, cts_act, s2_ff[5], !s2_ff[4]};
  assign crc_busy = state_ff == ssts_pkg::S_SHIFT &&
                    kind_ff == ssts_pkg::K_CRC;
  assign st = {snap_ff[3], under_ff, snap_ff[2], snap_ff[1], snap_ff[0],
               !full_ff && !crc_busy, txip_ff || extip_ff, 1'b0};

  // ---------------------------------------------------------------
  // Host registers and status latches
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ptr    = ptr_ff;
    nxt_intctl = intctl_ff;
    nxt_rxctl  = rxctl_ff;
    nxt_mode   = mode_ff;
    nxt_txctl  = txctl_ff;
    nxt_sync1  = sync1_ff;
    nxt_sync2  = sync2_ff;
    nxt_buf    = buf_ff;
    nxt_pdata  = pdata_ff;
    nxt_full   = full_ff && !ld_data;
    nxt_pend   = pend_ff;
    nxt_txip   = txip_ff;
    nxt_extip  = extip_ff;
    nxt_latch  = latch_ff;
    nxt_snap   = snap_ff;
    nxt_under  = under_ff;
    nxt_brk    = brk_ff;
    nxt_rdata  = rdata_ff;
    if (wr_stb && sel_ctrl) begin
      if (ptr_ff == ssts_pkg::PTR_CMD) begin
        nxt_ptr = wdata[2:0];
        if (wdata[5:3] == ssts_pkg::CMD_RST_EXT) begin
          nxt_latch = 1'b0;
          nxt_extip = 1'b0;
        end
        if (wdata[5:3] == ssts_pkg::CMD_RST_TXIP) begin
          nxt_txip = 1'b0;
        end
        if (wdata[7:6] == ssts_pkg::CRC_CMD_UNDER) begin
          nxt_under = 1'b0;
        end
      end else begin
        nxt_ptr = ssts_pkg::PTR_CMD;
        case (ptr_ff)
          ssts_pkg::PTR_INTCTL: nxt_intctl = wdata;
          ssts_pkg::PTR_RXCTL:  nxt_rxctl  = wdata;
          ssts_pkg::PTR_MODE:   nxt_mode   = wdata;
          ssts_pkg::PTR_TXCTL:  nxt_txctl  = wdata;
          ssts_pkg::PTR_SYNC1:  nxt_sync1  = wdata;
          ssts_pkg::PTR_SYNC2:  nxt_sync2  = wdata;
          default:              nxt_ptr    = ssts_pkg::PTR_CMD;
        endcase
      end
    end
    // A data write finding the buffer full is held and waited on.
    if ((wr_stb && !sel_ctrl) || pend_ff) begin
      if (!full_ff || ld_data) begin
        nxt_buf  = pend_ff ? pdata_ff : wdata;
        nxt_full = 1'b1;
        nxt_pend = 1'b0;
        nxt_txip = 1'b0;
      end else if (!pend_ff) begin
        nxt_pend  = 1'b1;
        nxt_pdata = wdata;
      end
    end
    if (ev_txip) begin
      nxt_txip = 1'b1;
    end
    if (ev_under) begin
      nxt_under = 1'b1;
    end
    if (rx_rise) begin
      nxt_brk = s2_ff[2] ? 8'h00 : (brk_live ? brk_ff : brk_ff + 8'h01);
    end
    // Detection runs only while unlatched, so a reset always releases.
    if (!latch_ff && (live != snap_ff || ev_under || ev_fill)) begin
      nxt_latch = 1'b1;
      nxt_extip = nxt_extip || intctl_ff[ssts_pkg::INT_EXT_IE];
    end
    if (!latch_ff) begin
      nxt_snap = live;
    end
    if (chan_rst) begin
      nxt_ptr    = ssts_pkg::PTR_CMD;
      nxt_intctl = ssts_pkg::REG_RST;
      nxt_rxctl  = ssts_pkg::REG_RST;
      nxt_txctl  = ssts_pkg::REG_RST;
      nxt_full   = 1'b0;
      nxt_pend   = 1'b0;
      nxt_txip   = 1'b0;
      nxt_extip  = 1'b0;
      nxt_latch  = 1'b0;
      nxt_under  = 1'b1;
    end
    if (rd_stb) begin
      nxt_rdata = (sel_ctrl && ptr_ff == ssts_pkg::PTR_CMD) ? st : 8'h00;
    end
    nxt_irq = nxt_extip ||
              (nxt_txip && nxt_intctl[ssts_pkg::INT_TX_IE]);
    nxt_dma = !nxt_full && nxt_txctl[ssts_pkg::TX_EN];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff        <= ssts_pkg::PTR_CMD;
      intctl_ff     <= ssts_pkg::REG_RST;
      rxctl_ff      <= ssts_pkg::REG_RST;
      mode_ff       <= ssts_pkg::REG_RST;
      txctl_ff      <= ssts_pkg::REG_RST;
      sync1_ff      <= ssts_pkg::REG_RST;
      sync2_ff      <= ssts_pkg::REG_RST;
      buf_ff        <= 8'h00;
      pdata_ff      <= 8'h00;
      full_ff       <= 1'b0;
      pend_ff       <= 1'b0;
      txip_ff       <= 1'b0;
      extip_ff      <= 1'b0;
      latch_ff      <= 1'b0;
      snap_ff       <= 4'h0;
      under_ff      <= 1'b1;
      brk_ff        <= 8'h00;
      rdata_ff      <= 8'h00;
      irq_ff        <= 1'b0;
      tx_dma_req_ff <= 1'b0;
      host_wait_ff  <= 1'b0;
      rts_n_ff      <= 1'b1;
      dtr_n_ff      <= 1'b1;
    end else if (ce) begin
      ptr_ff        <= nxt_ptr;
      intctl_ff     <= nxt_intctl;
      rxctl_ff      <= nxt_rxctl;
      mode_ff       <= nxt_mode;
      txctl_ff      <= nxt_txctl;
      sync1_ff      <= nxt_sync1;
      sync2_ff      <= nxt_sync2;
      buf_ff        <= nxt_buf;
      pdata_ff      <= nxt_pdata;
      full_ff       <= nxt_full;
      pend_ff       <= nxt_pend;
      txip_ff       <= nxt_txip;
      extip_ff      <= nxt_extip;
      latch_ff      <= nxt_latch;
      snap_ff       <= nxt_snap;
      under_ff      <= nxt_under;
      brk_ff        <= nxt_brk;
      rdata_ff      <= nxt_rdata;
      irq_ff        <= nxt_irq;
      tx_dma_req_ff <= nxt_dma;
      host_wait_ff  <= nxt_pend;
      rts_n_ff      <= !nxt_txctl[ssts_pkg::TX_RTS];
      dtr_n_ff      <= !nxt_txctl[ssts_pkg::TX_DTR];
    end
  end

  // ---------------------------------------------------------------
  // Transmit engine
  // ---------------------------------------------------------------
  always_comb begin
    is_async = mode_ff[3:2] != 2'b00;
    mult     = is_async ? ssts_pkg::mult_of(mode_ff[7:6]) : 7'd1;
    // Half-bit stop units; 1.5 stop bits needs a x16 clock or faster.
    stop_edges = 8'(({7'h00, mode_ff[3:2]} + 9'h001) * {2'b00, mult} >> 1);
    clen  = ssts_pkg::len_of(txctl_ff[6:5]);
    dmask = 8'hff >> (4'd8 - clen);
    txen  = txctl_ff[ssts_pkg::TX_EN] && !chan_rst &&
            (!rxctl_ff[ssts_pkg::RX_AUTO] || cts_act);
    nxt_state  = state_ff;
    nxt_kind   = kind_ff;
    nxt_sh     = sh_ff;
    nxt_nbits  = nbits_ff;
    nxt_div    = div_ff;
    nxt_crcinc = crcinc_ff;
    ld_data    = 1'b0;
    ev_under   = 1'b0;
    ev_fill    = 1'b0;
    ev_txip    = 1'b0;
    bit_v      = 1'b0;
    do_load    = 1'b0;
    if (!txen) begin
      nxt_state = ssts_pkg::S_OFF;
      nxt_kind  = ssts_pkg::K_SYNC;
    end else if (tx_fall) begin
      case (state_ff)
        ssts_pkg::S_OFF: begin
          do_load = !is_async || full_ff;
        end
        ssts_pkg::S_SHIFT: begin
          if (div_ff != 8'h01) begin
            nxt_div = div_ff - 8'h01;
          end else begin
            bit_v = crcinc_ff;
            if (nbits_ff != 5'd1) begin
              nxt_sh    = {1'b1, sh_ff[15:1]};
              nxt_nbits = nbits_ff - 5'd1;
              nxt_div   = {1'b0, mult};
            end else if (is_async) begin
              nxt_state = ssts_pkg::S_STOP;
              nxt_div   = stop_edges;
            end else begin
              do_load = 1'b1;
            end
          end
        end
        ssts_pkg::S_STOP: begin
          if (div_ff > 8'h01) begin
            nxt_div = div_ff - 8'h01;
          end else begin
            do_load = 1'b1;
          end
        end
        default: nxt_state = ssts_pkg::S_OFF;
      endcase
    end
    if (do_load) begin
      nxt_state = ssts_pkg::S_SHIFT;
      nxt_div   = {1'b0, mult};
      nxt_crcinc = 1'b0;
      if (full_ff) begin
        ld_data  = 1'b1;
        nxt_kind = ssts_pkg::K_DATA;
        ev_txip  = 1'b1;
        nxt_crcinc = !is_async && txctl_ff[ssts_pkg::TX_CRCEN];
        if (is_async) begin
          nxt_sh = {7'h00, buf_ff & dmask, 1'b0};
          if (mode_ff[ssts_pkg::MD_PAR_EN]) begin
            nxt_sh[clen + 4'd1] = mode_ff[ssts_pkg::MD_EVEN] ?
                                  ^(buf_ff & dmask) : ~^(buf_ff & dmask);
          end
          nxt_nbits = 5'd1 + {1'b0, clen} +
                      {4'h0, mode_ff[ssts_pkg::MD_PAR_EN]};
        end else begin
          nxt_sh    = {8'hff, buf_ff};
          nxt_nbits = {1'b0, clen};
        end
      end else if (is_async) begin
        nxt_state = ssts_pkg::S_OFF;
      end else if (under_ff || kind_ff == ssts_pkg::K_CRC) begin
        nxt_kind = ssts_pkg::K_SYNC;
        ev_fill  = kind_ff == ssts_pkg::K_DATA;
        ev_txip  = kind_ff == ssts_pkg::K_CRC;
        if (mode_ff[5:4] == ssts_pkg::SYNC_16) begin
          nxt_sh    = {sync2_ff, sync1_ff};
          nxt_nbits = 5'd16;
        end else begin
          nxt_sh    = {8'hff, sync1_ff};
          nxt_nbits = 5'd8;
        end
      end else begin
        nxt_kind  = ssts_pkg::K_CRC;
        ev_under  = 1'b1;
        nxt_sh    = ssts_pkg::rev16(crc_q);
        nxt_nbits = 5'd16;
      end
    end
    if (nxt_txctl[ssts_pkg::TX_BRK]) begin
      nxt_txd = 1'b0;
    end else if (nxt_state == ssts_pkg::S_SHIFT) begin
      nxt_txd = nxt_sh[0];
    end else begin
      nxt_txd = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff  <= ssts_pkg::S_OFF;
      kind_ff   <= ssts_pkg::K_SYNC;
      sh_ff     <= 16'hffff;
      nbits_ff  <= 5'd0;
      div_ff    <= 8'h00;
      crcinc_ff <= 1'b0;
      txd_ff    <= 1'b1;
    end else if (ce) begin
      state_ff  <= nxt_state;
      kind_ff   <= nxt_kind;
      sh_ff     <= nxt_sh;
      nbits_ff  <= nxt_nbits;
      div_ff    <= nxt_div;
      crcinc_ff <= nxt_crcinc;
      txd_ff    <= nxt_txd;
    end
  end

  ssts_crc16 ssts_crc16_inst (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (crc_clr),
    .bit_v    (bit_v),
    .bit_in   (sh_ff[0]),
    .poly_sel (txctl_ff[ssts_pkg::TX_POLY]),
    .crc_ff   (crc_q)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_load_data;
    ce && ld_data && !is_async;
  endsequence

  property p_crc_incl;
    seq_load_data ##0 txctl_ff[ssts_pkg::TX_CRCEN] |=> crcinc_ff;
  endproperty
  a_crc_incl: assert property (p_crc_incl)
    else $error("crc inclusion not taken at load");

  property p_idle_high;
    (state_ff == ssts_pkg::S_OFF && !txctl_ff[ssts_pkg::TX_BRK])
      |-> txd_ff;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not marking while off");

  property p_break_low;
    txctl_ff[ssts_pkg::TX_BRK] |-> !txd_ff;
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break not spacing");

  property p_ext_irq;
    extip_ff |-> irq_ff;
  endproperty
  a_ext_irq: assert property (p_ext_irq)
    else $error("status interrupt not raised");

  property p_ext_clear;
    (ce && cmd_wr && wdata[5:3] == ssts_pkg::CMD_RST_EXT && !ev_under &&
     !ev_fill && (latch_ff || live == snap_ff)) |=> !extip_ff && !latch_ff;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("status latch survived reset command");

  property p_dma_empty;
    tx_dma_req_ff |-> !full_ff;
  endproperty
  a_dma_empty: assert property (p_dma_empty)
    else $error("dma request with full buffer");

  property p_wait;
    (ce && wr_stb && !sel_ctrl && full_ff && !ld_data && !pend_ff)
      |=> host_wait_ff && pend_ff;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait not asserted on blocked write");

  property p_chan_under;
    (ce && chan_rst) |=> under_ff && state_ff == ssts_pkg::S_OFF;
  endproperty
  a_chan_under: assert property (p_chan_under)
    else $error("channel reset left underrun clear");

  property p_crc_status;
    crc_busy |-> st[ssts_pkg::ST_UNDER] && !st[ssts_pkg::ST_TXBE];
  endproperty
  a_crc_status: assert property (p_crc_status)
    else $error("wrong status while sending crc");

  property p_crc_clear;
    (ce && crc_clr) |=> crc_q == ssts_pkg::CRC_INIT;
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("crc generator not cleared");

  property p_auto;
    (ce && rxctl_ff[ssts_pkg::RX_AUTO] && !cts_act)
      |=> state_ff == ssts_pkg::S_OFF;
  endproperty
  a_auto: assert property (p_auto)
    else $error("transmitter ran without clear-to-send");

  property p_load_ip;
    (ce && ld_data) |=> txip_ff;
  endproperty
  a_load_ip: assert property (p_load_ip)
    else $error("buffer empty pending not set");

endmodule // ssts_top

// ==== tb_sync_serial_tx_and_status.sv ====
// Purpose: Directed bench for the serial transmit and status channel.
// Assumes: Host strobes change on the falling clock edge.
// Notes:   A short break count is set, though the peer never drives a break.
`timescale 1ns/1ps

module tb_sync_serial_tx_and_status;
  logic       clk, rst, wr_stb, rd_stb, sel_ctrl, run, cts_n, cd_n;
  logic [7:0] wdata, rdata_ff, v;
  logic       host_wait_ff, irq_ff, tx_dma_req_ff, tclk, rxd, hit;
  logic       txd_ff, rts_n_ff, dtr_n_ff;
  int         err_count, num_checks;

  ssts_top #(.BRK_BITS(4)) ssts_top_inst (
    .clk(clk), .rst(rst), .ce(1'b1), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .sel_ctrl(sel_ctrl), .wdata(wdata), .rdata_ff(rdata_ff),
    .host_wait_ff(host_wait_ff), .irq_ff(irq_ff),
    .tx_dma_req_ff(tx_dma_req_ff), .transmit_clock(tclk),
    .receive_clock(tclk), .rxd(rxd), .cts_n(cts_n), .cd_n(cd_n),
    .sync_detect_pin(1'b0), .txd_ff(txd_ff), .rts_n_ff(rts_n_ff),
    .dtr_n_ff(dtr_n_ff));
  ssts_peer #(.PAT(8'h96)) ssts_peer_inst (
    .run(run), .txd(txd_ff), .tclk(tclk), .rxd(rxd), .hit(hit));

  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // A spare edge after each strobe keeps back-to-back calls clean.
  task automatic wr(input logic s, input logic [7:0] d);
    wr_stb = 1'b1;
    sel_ctrl = s;
    wdata = d;
    @(negedge clk);
    wr_stb = 1'b0;
    @(negedge clk);
  endtask
  task automatic wreg(input logic [2:0] p, input logic [7:0] d);
    wr(1'b1, {5'h00, p});
    wr(1'b1, d);
  endtask
  task automatic rds();
    rd_stb = 1'b1;
    sel_ctrl = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    @(negedge clk);
    v = rdata_ff;
  endtask
  // Polls irq_ff (w = 0) or host_wait_ff (w = 1) for at most n edges.
  task automatic waitfor(input int w, input logic e, input int n);
    repeat (n) if ((w == 0 ? irq_ff : host_wait_ff) !== e) @(negedge clk);
  endtask
  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    err_count++;
    results();
  end
  initial begin
    {rst, run, wr_stb, rd_stb, sel_ctrl, wdata} = {1'b1, 12'h000};
    {cts_n, cd_n} = 2'b11;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("txd_idle", txd_ff, 1'b1);
    rds();
    chk("status", v, 8'h44);
    wreg(3'h4, 8'h00);
    wreg(3'h6, 8'h96);
    wreg(3'h1, 8'h01);
    cd_n = 1'b0;
    waitfor(0, 1'b1, 20);
    chk("irq_cd", irq_ff, 1'b1);
    rds();
    chk("cd_bit", v & 8'h08, 8'h08);
    wr(1'b1, 8'h10);
    repeat (2) @(negedge clk);
    chk("irq_ext", irq_ff, 1'b0);
    wreg(3'h1, 8'h02);
    wreg(3'h5, 8'h18);
    repeat (3) @(negedge clk);
    chk("break", txd_ff, 1'b0);
    wreg(3'h5, 8'h0B);
    chk("rts", rts_n_ff, 1'b0);
    chk("dma_on", tx_dma_req_ff, 1'b1);
    run = 1'b1;
    repeat (400) @(negedge clk);
    chk("sync", hit, 1'b1);
    wr(1'b0, 8'h5A);
    chk("dma_off", tx_dma_req_ff, 1'b0);
    waitfor(0, 1'b1, 300);
    chk("irq_txbe", irq_ff, 1'b1);
    wr(1'b0, 8'h5A);
    wr(1'b0, 8'hC3);
    chk("wait", host_wait_ff, 1'b1);
    waitfor(1, 1'b0, 300);
    chk("wait_end", host_wait_ff, 1'b0);
    waitfor(0, 1'b1, 300);
    wr(1'b1, 8'h28);
    chk("irq_txip", irq_ff, 1'b0);
    repeat (400) @(negedge clk);
    rds();
    chk("underrun", v & 8'h44, 8'h44);
    wr(1'b1, 8'hE8);
    chk("irq_clr", irq_ff, 1'b0);
    rds();
    chk("eom_clr", v & 8'h40, 8'h00);
    repeat (120) @(negedge clk);
    rds();
    chk("crc_st", v & 8'h44, 8'h40);
    waitfor(0, 1'b1, 400);
    chk("irq_crc", irq_ff, 1'b1);
    wreg(3'h3, 8'h20);
    repeat (80) @(negedge clk);
    chk("auto_off", txd_ff, 1'b1);
    wr(1'b1, 8'h10);
    cts_n = 1'b0;
    repeat (8) @(negedge clk);
    rds();
    chk("cts_bit", v & 8'h20, 8'h20);
    wr(1'b1, 8'h18);
    rds();
    chk("chan_st", v, 8'h6C);
    chk("chan_rts", rts_n_ff, 1'b1);
    chk("chan_irq", irq_ff, 1'b0);
    results();
  end
endmodule // tb_sync_serial_tx_and_status
